/* File: core/isc_pkg.sv */
// constants, types and command encodings of the serial configuration port
package isc_pkg;

  localparam int IR_W = 8;
  localparam int DR_W = 26;
  localparam int FIFO_DEPTH = 8;
  localparam int SECTORS = 8;
  localparam int ENABLE_LEN = 2;
  localparam int STATUS_LEN = 8;
  localparam int BYPASS_LEN = 1;
  localparam int DR_DATA_LSB = 0;
  localparam int DR_ADDR_LSB = 8;
  localparam int DR_TGT_LSB = 24;
  localparam int EN_OD_BIT = 0;
  localparam int EN_SIDEBAND_BIT = 1;
  localparam logic [IR_W-1:0] IR_CAPTURE = 8'h01;
  localparam logic [7:0] BLANK_BYTE = 8'hFF;

  // controller states with the customary four-bit codes
  typedef enum logic [3:0] {
    TAP_EXIT2_DR = 4'h0,
    TAP_EXIT1_DR = 4'h1,
    TAP_SHIFT_DR = 4'h2,
    TAP_PAUSE_DR = 4'h3,
    TAP_SELECT_IR = 4'h4,
    TAP_UPDATE_DR = 4'h5,
    TAP_CAPTURE_DR = 4'h6,
    TAP_SELECT_DR = 4'h7,
    TAP_EXIT2_IR = 4'h8,
    TAP_EXIT1_IR = 4'h9,
    TAP_SHIFT_IR = 4'hA,
    TAP_PAUSE_IR = 4'hB,
    TAP_IDLE = 4'hC,
    TAP_UPDATE_IR = 4'hD,
    TAP_CAPTURE_IR = 4'hE,
    TAP_RESET = 4'hF
  } tap_e;

  // instruction codes; anything else behaves as bypass
  typedef enum logic [IR_W-1:0] {
    INS_ENABLE = 8'h0C,
    INS_DISABLE = 8'h0F,
    INS_PROGRAM = 8'h11,
    INS_ERASE = 8'h12,
    INS_CHIP_ERASE = 8'h13,
    INS_READ = 8'h14,
    INS_CLEAR = 8'h15,
    INS_STATUS = 8'h16,
    INS_BYPASS = 8'hFF
  } ins_e;

  typedef enum logic [1:0] {
    OP_PROGRAM = 2'h0,
    OP_ERASE = 2'h1,
    OP_CHIP_ERASE = 2'h2
  } mem_op_e;

  typedef enum logic [1:0] {
    TGT_PRIMARY = 2'h0,
    TGT_SECONDARY = 2'h1,
    TGT_LOGIC = 2'h2,
    TGT_CONFIG = 2'h3
  } target_e;

  // one queued operation for the memory and logic module
  typedef struct packed {
    mem_op_e op;
    target_e target;
    logic [15:0] addr;
    logic [7:0] data;
  } mem_cmd_s;

endpackage : isc_pkg

/* File: core/isc_port.sv */
// serial configuration port with its command queue
module isc_cmd_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = isc_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);

  // refuse depths the pointer wrap cannot serve
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_s;

  fifo_s s;
  fifo_s next_s;
  logic push;
  logic pop;

  // honest full and empty from the fill count
  assign in_ready = s.cnt != (AW+1)'(DEPTH);
  assign out_valid = s.cnt != '0;
  assign out_data = s.mem[s.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and storage update
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = in_data;
      next_s.wp = s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = s.rp + 1'b1;
    end
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : isc_cmd_fifo

module isc_port #(
  parameter int FIFO_DEPTH = isc_pkg::FIFO_DEPTH,
  parameter int SECTORS = isc_pkg::SECTORS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial test pins on port C: mode 0, clock 1, data in 5, data out 6
  input wire logic tms_pin,
  input wire logic tck_pin,
  input wire logic tdi_pin,
  output logic tdo_pin,
  output logic tdo_oe_n,
  // sideband pins on port C bits 3 and 4
  output logic sideband_busy_status_out,
  output logic sideband_busy_status_oe_n,
  output logic sideband_error_flag_out,
  output logic sideband_error_flag_oe_n,
  // chip reset and configuration
  input wire logic chip_reset_pin,
  input wire logic device_blank,
  input wire logic keep_jtag_pins,
  input wire logic security_bit,
  input wire logic [SECTORS-1:0] primary_protect,
  input wire logic [SECTORS-1:0] secondary_protect,
  output logic jtag_pin_select,
  output logic isc_active,
  output logic secured,
  // memory_logic_module command stream
  output isc_pkg::mem_cmd_s mem_cmd,
  output logic mem_cmd_valid,
  input wire logic mem_cmd_ready,
  // memory_logic_module status and read path
  input wire logic mem_busy,
  input wire logic mem_fail,
  input wire logic [7:0] mem_rdata,
  output logic [15:0] mem_read_addr,
  output isc_pkg::target_e mem_read_target
);

  localparam int SW = $clog2(SECTORS);

  if (SECTORS < 2 || SECTORS > 256) begin : g_bad_sectors
    $error("sector count out of range");
  end

  typedef struct packed {
    logic [1:0] tck_sync;
    logic [1:0] tms_sync;
    logic [1:0] tdi_sync;
    logic [1:0] crst_sync;
    logic tck_prev;
    logic crst_prev;
    isc_pkg::tap_e tap;
    logic [isc_pkg::IR_W-1:0] ir_shift;
    isc_pkg::ins_e ir;
    logic [isc_pkg::DR_W-1:0] dr;
    logic active;
    logic sideband_en;
    logic open_drain;
    logic disable_seen;
    logic error;
    logic refused;
    logic secured;
    logic strap_done;
    logic push;
    isc_pkg::mem_cmd_s push_cmd;
    logic [15:0] read_addr;
    isc_pkg::target_e read_tgt;
    logic tdo;
    logic tdo_oe_n;
    logic busy_o;
    logic busy_oe_n;
    logic err_o;
    logic err_oe_n;
    logic pin_sel;
  } port_s;

  port_s s;
  port_s next_s;
  logic fifo_ready;
  logic fifo_valid;

  // next controller state from mode select
  function automatic isc_pkg::tap_e tap_step(isc_pkg::tap_e t, logic tms);
    case (t)
      isc_pkg::TAP_RESET: tap_step = tms ? isc_pkg::TAP_RESET : isc_pkg::TAP_IDLE;
      isc_pkg::TAP_IDLE: tap_step = tms ? isc_pkg::TAP_SELECT_DR : isc_pkg::TAP_IDLE;
      isc_pkg::TAP_SELECT_DR: tap_step = tms ? isc_pkg::TAP_SELECT_IR : isc_pkg::TAP_CAPTURE_DR;
      isc_pkg::TAP_CAPTURE_DR: tap_step = tms ? isc_pkg::TAP_EXIT1_DR : isc_pkg::TAP_SHIFT_DR;
      isc_pkg::TAP_SHIFT_DR: tap_step = tms ? isc_pkg::TAP_EXIT1_DR : isc_pkg::TAP_SHIFT_DR;
      isc_pkg::TAP_EXIT1_DR: tap_step = tms ? isc_pkg::TAP_UPDATE_DR : isc_pkg::TAP_PAUSE_DR;
      isc_pkg::TAP_PAUSE_DR: tap_step = tms ? isc_pkg::TAP_EXIT2_DR : isc_pkg::TAP_PAUSE_DR;
      isc_pkg::TAP_EXIT2_DR: tap_step = tms ? isc_pkg::TAP_UPDATE_DR : isc_pkg::TAP_SHIFT_DR;
      isc_pkg::TAP_UPDATE_DR: tap_step = tms ? isc_pkg::TAP_SELECT_DR : isc_pkg::TAP_IDLE;
      isc_pkg::TAP_SELECT_IR: tap_step = tms ? isc_pkg::TAP_RESET : isc_pkg::TAP_CAPTURE_IR;
      isc_pkg::TAP_CAPTURE_IR: tap_step = tms ? isc_pkg::TAP_EXIT1_IR : isc_pkg::TAP_SHIFT_IR;
      isc_pkg::TAP_SHIFT_IR: tap_step = tms ? isc_pkg::TAP_EXIT1_IR : isc_pkg::TAP_SHIFT_IR;
      isc_pkg::TAP_EXIT1_IR: tap_step = tms ? isc_pkg::TAP_UPDATE_IR : isc_pkg::TAP_PAUSE_IR;
      isc_pkg::TAP_PAUSE_IR: tap_step = tms ? isc_pkg::TAP_EXIT2_IR : isc_pkg::TAP_PAUSE_IR;
      isc_pkg::TAP_EXIT2_IR: tap_step = tms ? isc_pkg::TAP_UPDATE_IR : isc_pkg::TAP_SHIFT_IR;
      isc_pkg::TAP_UPDATE_IR: tap_step = tms ? isc_pkg::TAP_SELECT_DR : isc_pkg::TAP_IDLE;
      default: tap_step = isc_pkg::TAP_RESET;
    endcase
  endfunction : tap_step

  // data register length selected by the instruction
  function automatic int dr_len(isc_pkg::ins_e i);
    case (i)
      isc_pkg::INS_ENABLE: dr_len = isc_pkg::ENABLE_LEN;
      isc_pkg::INS_STATUS: dr_len = isc_pkg::STATUS_LEN;
      isc_pkg::INS_PROGRAM, isc_pkg::INS_ERASE, isc_pkg::INS_CHIP_ERASE,
      isc_pkg::INS_READ: dr_len = isc_pkg::DR_W;
      default: dr_len = isc_pkg::BYPASS_LEN;
    endcase
  endfunction : dr_len

  // memory commands carry target, address and data in one scan
  function automatic logic is_mem_op(isc_pkg::ins_e i);
    is_mem_op = i == isc_pkg::INS_PROGRAM || i == isc_pkg::INS_ERASE
             || i == isc_pkg::INS_CHIP_ERASE;
  endfunction : is_mem_op

  isc_cmd_fifo #(
    .WIDTH($bits(isc_pkg::mem_cmd_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(s.push),
    .in_data(s.push_cmd),
    .in_ready(fifo_ready),
    .out_valid(fifo_valid),
    .out_data(mem_cmd),
    .out_ready(mem_cmd_ready)
  );

  assign mem_cmd_valid = fifo_valid;

  // whole port behaviour, stepped on sampled clock edges
  always_comb begin
    logic rise;
    logic fall;
    logic tms;
    logic tdi;
    logic ready;
    logic crst_release;
    logic protect;
    logic [SW-1:0] sector;
    isc_pkg::target_e tgt;
    int len;
    rise = 1'b0;
    fall = 1'b0;
    tms = 1'b0;
    tdi = 1'b0;
    ready = 1'b0;
    crst_release = 1'b0;
    protect = 1'b0;
    sector = '0;
    tgt = isc_pkg::TGT_PRIMARY;
    len = 0;
    next_s = s;

    // two-stage synchronisers on every pin input
    next_s.tck_sync = {s.tck_sync[0], tck_pin};
    next_s.tms_sync = {s.tms_sync[0], tms_pin};
    next_s.tdi_sync = {s.tdi_sync[0], tdi_pin};
    next_s.crst_sync = {s.crst_sync[0], chip_reset_pin};
    next_s.tck_prev = s.tck_sync[1];
    next_s.crst_prev = s.crst_sync[1];
    rise = s.tck_sync[1] && !s.tck_prev;
    fall = !s.tck_sync[1] && s.tck_prev;
    tms = s.tms_sync[1];
    tdi = s.tdi_sync[1];
    crst_release = s.crst_prev && !s.crst_sync[1];

    // secured state caught from the strap after reset release
    if (!s.strap_done) begin
      next_s.strap_done = 1'b1;
      next_s.secured = security_bit;
    end

    // queued command waits until the queue has room
    if (s.push && fifo_ready) begin
      next_s.push = 1'b0;
    end

    // a chip reset after disable also clears the error
    if (crst_release && s.disable_seen) begin
      next_s.error = 1'b0;
      next_s.disable_seen = 1'b0;
    end

    if (rise) begin
      len = dr_len(s.ir);
      case (s.tap)
        isc_pkg::TAP_RESET: begin
          next_s.ir = isc_pkg::INS_BYPASS;
        end
        isc_pkg::TAP_CAPTURE_IR: begin
          next_s.ir_shift = isc_pkg::IR_CAPTURE;
        end
        isc_pkg::TAP_SHIFT_IR: begin
          next_s.ir_shift = {tdi, s.ir_shift[isc_pkg::IR_W-1:1]};
        end
        isc_pkg::TAP_UPDATE_IR: begin
          // unknown codes, boundary scan ones included, fall to bypass
          case (s.ir_shift)
            isc_pkg::INS_ENABLE, isc_pkg::INS_DISABLE, isc_pkg::INS_PROGRAM,
            isc_pkg::INS_ERASE, isc_pkg::INS_CHIP_ERASE, isc_pkg::INS_READ,
            isc_pkg::INS_CLEAR, isc_pkg::INS_STATUS:
              next_s.ir = isc_pkg::ins_e'(s.ir_shift);
            default: next_s.ir = isc_pkg::INS_BYPASS;
          endcase
          if (s.ir_shift == isc_pkg::INS_CLEAR) begin
            next_s.error = 1'b0;
            next_s.refused = 1'b0;
          end
          if (s.ir_shift == isc_pkg::INS_DISABLE) begin
            next_s.active = 1'b0;
            next_s.sideband_en = 1'b0;
            next_s.disable_seen = 1'b1;
          end
        end
        isc_pkg::TAP_CAPTURE_DR: begin
          ready = !mem_busy && !fifo_valid && !s.push;
          if (s.ir == isc_pkg::INS_STATUS) begin
            next_s.dr = isc_pkg::DR_W'({3'h0, s.refused, !fifo_ready, s.secured,
                                        s.error, ready});
          end else if (s.ir == isc_pkg::INS_READ) begin
            if (s.secured) begin
              next_s.dr[isc_pkg::DR_DATA_LSB +: 8] = 8'h00;
            end else if (device_blank) begin
              next_s.dr[isc_pkg::DR_DATA_LSB +: 8] = isc_pkg::BLANK_BYTE;
            end else begin
              next_s.dr[isc_pkg::DR_DATA_LSB +: 8] = mem_rdata;
            end
          end else if (len == isc_pkg::BYPASS_LEN) begin
            next_s.dr[0] = 1'b0;
          end
        end
        isc_pkg::TAP_SHIFT_DR: begin
          next_s.dr = s.dr >> 1;
          next_s.dr[len-1] = tdi;
        end
        isc_pkg::TAP_UPDATE_DR: begin
          tgt = isc_pkg::target_e'(s.dr[isc_pkg::DR_TGT_LSB +: 2]);
          sector = s.dr[isc_pkg::DR_ADDR_LSB +: SW];
          protect = (tgt == isc_pkg::TGT_PRIMARY && primary_protect[sector])
                 || (tgt == isc_pkg::TGT_SECONDARY && secondary_protect[sector]);
          if (s.ir == isc_pkg::INS_ENABLE) begin
            next_s.active = 1'b1;
            next_s.sideband_en = s.dr[isc_pkg::EN_SIDEBAND_BIT];
            next_s.open_drain = s.dr[isc_pkg::EN_OD_BIT];
            next_s.disable_seen = 1'b0;
          end else if (s.ir == isc_pkg::INS_READ && s.active) begin
            next_s.read_addr = s.dr[isc_pkg::DR_ADDR_LSB +: 16];
            next_s.read_tgt = tgt;
          end else if (is_mem_op(s.ir) && s.active) begin
            if (s.push
                || (s.secured && s.ir != isc_pkg::INS_CHIP_ERASE)
                || (s.ir == isc_pkg::INS_ERASE && protect)) begin
              next_s.refused = 1'b1;
            end else begin
              next_s.push = 1'b1;
              next_s.push_cmd.target = tgt;
              next_s.push_cmd.addr = s.dr[isc_pkg::DR_ADDR_LSB +: 16];
              next_s.push_cmd.data = s.dr[isc_pkg::DR_DATA_LSB +: 8];
              case (s.ir)
                isc_pkg::INS_ERASE: next_s.push_cmd.op = isc_pkg::OP_ERASE;
                isc_pkg::INS_CHIP_ERASE: begin
                  next_s.push_cmd.op = isc_pkg::OP_CHIP_ERASE;
                  next_s.secured = 1'b0;
                end
                default: next_s.push_cmd.op = isc_pkg::OP_PROGRAM;
              endcase
            end
          end
        end
        default: begin
        end
      endcase
      next_s.tap = tap_step(s.tap, tms);
    end

    // serial data out changes on the falling clock edge
    if (fall) begin
      next_s.tdo = s.tap == isc_pkg::TAP_SHIFT_IR ? s.ir_shift[0] : s.dr[0];
    end
    next_s.tdo_oe_n = !s.active;

    // failed erase or program latches the error; set beats clear
    if (mem_fail) begin
      next_s.error = 1'b1;
    end

    // sideband pins, push-pull or open-drain, idle until enabled
    ready = !mem_busy && !fifo_valid && !s.push;
    if (!s.sideband_en) begin
      next_s.busy_o = 1'b1;
      next_s.busy_oe_n = 1'b1;
      next_s.err_o = 1'b1;
      next_s.err_oe_n = 1'b1;
    end else if (s.open_drain) begin
      next_s.busy_o = 1'b0;
      next_s.busy_oe_n = ready;
      next_s.err_o = 1'b0;
      next_s.err_oe_n = !next_s.error;
    end else begin
      next_s.busy_o = ready;
      next_s.busy_oe_n = 1'b0;
      next_s.err_o = !next_s.error;
      next_s.err_oe_n = 1'b0;
    end

    // blank parts give port C to the test function
    next_s.pin_sel = device_blank || keep_jtag_pins;
  end

  // state register; pins are inputs from reset onward
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.tap <= isc_pkg::TAP_RESET;
      s.ir <= isc_pkg::INS_BYPASS;
      s.secured <= 1'b1;
      s.tdo_oe_n <= 1'b1;
      s.busy_o <= 1'b1;
      s.busy_oe_n <= 1'b1;
      s.err_o <= 1'b1;
      s.err_oe_n <= 1'b1;
      s.pin_sel <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign tdo_pin = s.tdo;
  assign tdo_oe_n = s.tdo_oe_n;
  assign sideband_busy_status_out = s.busy_o;
  assign sideband_busy_status_oe_n = s.busy_oe_n;
  assign sideband_error_flag_out = s.err_o;
  assign sideband_error_flag_oe_n = s.err_oe_n;
  assign jtag_pin_select = s.pin_sel;
  assign isc_active = s.active;
  assign secured = s.secured;
  assign mem_read_addr = s.read_addr;
  assign mem_read_target = s.read_tgt;

endmodule : isc_port

/* File: dv/isc_port_assertions.sv */
// checker watching the serial configuration port at its pins
module isc_port_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link and chip reset
  input wire logic tck_pin,
  input wire logic tdo_oe_n,
  input wire logic chip_reset_pin,
  // sideband pins
  input wire logic sideband_busy_status_out,
  input wire logic sideband_busy_status_oe_n,
  input wire logic sideband_error_flag_out,
  input wire logic sideband_error_flag_oe_n,
  // state and command stream
  input wire logic security_bit,
  input wire logic isc_active,
  input wire logic secured,
  input wire isc_pkg::mem_cmd_s mem_cmd,
  input wire logic mem_cmd_valid,
  input wire logic mem_cmd_ready,
  input wire logic mem_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [3:0] quiet;
  logic tck_q;
  logic crst_q;
  logic err_low;
  assign err_low = !sideband_error_flag_out && !sideband_error_flag_oe_n;
  // cycles since the link clock or chip reset last moved, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quiet <= 4'h0;
      tck_q <= 1'b0;
      crst_q <= 1'b0;
    end else begin
      tck_q <= tck_pin;
      crst_q <= chip_reset_pin;
      quiet <= (tck_pin != tck_q || chip_reset_pin != crst_q) ? 4'h0 :
        ((quiet == 4'hF) ? quiet : quiet + 4'h1);
    end
  end
  // module busy long enough, or idle long enough, to reach the status pin
  sequence s_busy_held;
    (mem_busy && !sideband_busy_status_oe_n) ##1 mem_busy [*2];
  endsequence
  sequence s_idle_held;
    (!mem_busy && !mem_cmd_valid && !sideband_busy_status_oe_n) [*4];
  endsequence
  // pin drivers only after the enabling command
  property p_tdo_quiet;
    !tdo_oe_n |-> $past(isc_active) || $past(isc_active, 2);
  endproperty
  property p_enable_drives;
    $rose(isc_active) |=> !tdo_oe_n;
  endproperty
  property p_side_quiet;
    !(sideband_busy_status_oe_n && sideband_error_flag_oe_n) |->
      $past(isc_active) || $past(isc_active, 2);
  endproperty
  a_tdo_quiet: assert property (p_tdo_quiet) else $error("data out driven early");
  a_enable_drives: assert property (p_enable_drives) else $error("data out not driven");
  a_side_quiet: assert property (p_side_quiet) else $error("sideband driven early");
  // error flag and status pin
  property p_err_hold;
    err_low && quiet >= 4'h8 |=> err_low;
  endproperty
  property p_busy;
    s_busy_held |-> !sideband_busy_status_out && !sideband_busy_status_oe_n;
  endproperty
  property p_ready;
    s_idle_held |-> sideband_busy_status_out;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag dropped alone");
  a_busy: assert property (p_busy) else $error("status high while busy");
  a_ready: assert property (p_ready) else $error("status low while idle");
  // command head and security strap
  property p_cmd_hold;
    mem_cmd_valid && !mem_cmd_ready |=> mem_cmd_valid && $stable(mem_cmd);
  endproperty
  property p_secured_load;
    $past(rst) |-> ##1 secured == $past(security_bit);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command head moved");
  a_secured_load: assert property (p_secured_load) else $error("strap not loaded");
endmodule : isc_port_assertions

bind isc_port isc_port_assertions u_isc_port_assertions (
  .clk(clk), .rst(rst), .tck_pin(tck_pin), .tdo_oe_n(tdo_oe_n), .chip_reset_pin(chip_reset_pin),
  .sideband_busy_status_out(sideband_busy_status_out),
  .sideband_busy_status_oe_n(sideband_busy_status_oe_n),
  .sideband_error_flag_out(sideband_error_flag_out),
  .sideband_error_flag_oe_n(sideband_error_flag_oe_n), .security_bit(security_bit),
  .isc_active(isc_active), .secured(secured), .mem_cmd(mem_cmd),
  .mem_cmd_valid(mem_cmd_valid), .mem_cmd_ready(mem_cmd_ready), .mem_busy(mem_busy)
);

/* File: dv/jtag_host_model.sv */
// controller model that clocks frames into the serial port
module jtag_host_model (
  // bench clock
  input wire logic clk,
  // link pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  timeunit 1ns;
  timeprecision 1ps;
  // link rests with its clock low and the mode line high
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one 160 ns link clock; data out is taken just before the rise
  task automatic pulse(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    repeat (8) @(negedge clk);
    q = tdo;
    tck = 1'b1;
    repeat (8) @(negedge clk);
    tck = 1'b0;
  endtask : pulse
  // one frame from idle back to idle, lsb first; clock stands still afterwards
  task automatic scan(input logic ir, input int n, input logic [25:0] din,
                      output logic [25:0] dout);
    logic q;
    dout = 26'h0;
    pulse(1'b1, 1'b0, q);
    if (ir) pulse(1'b1, 1'b0, q);
    pulse(1'b0, 1'b0, q);
    pulse(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      pulse(i == n - 1, din[i], q);
      dout[i] = q;
    end
    pulse(1'b1, 1'b0, q);
    pulse(1'b0, ~din[n-1], q); // idle data line shows the inverse of its last bit
  endtask : scan
endmodule : jtag_host_model

/* File: dv/test_isc_port.sv */
// self-checking bench for the serial configuration port
module test_isc_port;
  timeunit 1ns;
  timeprecision 1ps;
  // one row: instruction, expected operation and the frame shifted in
  typedef struct packed {
    logic [7:0] ins;
    isc_pkg::mem_op_e op;
    logic [25:0] dr;
  } row_s;
  logic clk, rst, tms, tck, tdi, tdo, tdo_w, tdo_oe_n, st, st_oe_n, er, er_oe_n;
  logic crst, blank, keep, sec, pin_sel, active, secured, valid, ready, busy, fail;
  logic [7:0] pprot, sprot, rdata;
  logic [15:0] raddr;
  logic [1:0] rtgt;
  logic link_on;
  logic [25:0] dout;
  isc_pkg::mem_cmd_s cmd;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  row_s rows [6];
  assign tdo_w = tdo_oe_n ? 1'b1 : tdo; // released data out pulled high
  isc_port u_isc_port (
    .clk(clk), .rst(rst), .tms_pin(tms), .tck_pin(tck), .tdi_pin(tdi), .tdo_pin(tdo),
    .tdo_oe_n(tdo_oe_n), .sideband_busy_status_out(st), .sideband_busy_status_oe_n(st_oe_n),
    .sideband_error_flag_out(er), .sideband_error_flag_oe_n(er_oe_n), .chip_reset_pin(crst),
    .device_blank(blank), .keep_jtag_pins(keep), .security_bit(sec), .primary_protect(pprot),
    .secondary_protect(sprot), .jtag_pin_select(pin_sel), .isc_active(active),
    .secured(secured), .mem_cmd(cmd), .mem_cmd_valid(valid), .mem_cmd_ready(ready),
    .mem_busy(busy), .mem_fail(fail), .mem_rdata(rdata), .mem_read_addr(raddr),
    .mem_read_target(rtgt)
  );
  jtag_host_model u_jtag_host_model (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_w));
  // 100 MHz clock and a cycle ceiling against hangs
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      stop_test();
    end
  end
  // comparison, frames and command intake
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  task automatic waitc(input int n);
    repeat (n) @(negedge clk);
  endtask : waitc
  task automatic ir(input logic [7:0] code);
    u_jtag_host_model.scan(1'b1, 8, {18'h0, code}, dout);
    chk(32'(dout[7:0]), link_on ? 32'(isc_pkg::IR_CAPTURE) : 32'hFF);
    if (code == isc_pkg::INS_DISABLE) link_on = 1'b0;
  endtask : ir
  task automatic dr(input int n, input logic [25:0] d);
    u_jtag_host_model.scan(1'b0, n, d, dout);
  endtask : dr
  task automatic enable(input logic [1:0] mode);
    ir(isc_pkg::INS_ENABLE);
    dr(2, {24'h0, mode});
    waitc(2);
    link_on = 1'b1;
  endtask : enable
  task automatic take(input isc_pkg::mem_cmd_s e);
    for (int k = 0; k < 60 && valid !== 1'b1; k++) waitc(1);
    waitc(3);
    chk(32'(cmd), 32'(e));
    ready = 1'b1;
    waitc(1);
    ready = 1'b0;
  endtask : take
  task automatic do_reset(input int n);
    logic q;
    rst = 1'b1;
    link_on = 1'b0;
    waitc(n);
    rst = 1'b0;
    waitc(4);
    u_jtag_host_model.pulse(1'b0, 1'b0, q);
  endtask : do_reset
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  // main sequence
  initial begin
    crst = 1'b1;
    blank = 1'b1;
    keep = 1'b0;
    sec = 1'b0;
    pprot = 8'h08;
    sprot = 8'h00;
    rdata = 8'h5A;
    ready = 1'b0;
    busy = 1'b0;
    fail = 1'b0;
    rows[0] = '{isc_pkg::INS_PROGRAM, isc_pkg::OP_PROGRAM, {2'h0, 16'h0010, 8'hA5}};
    rows[1] = '{isc_pkg::INS_PROGRAM, isc_pkg::OP_PROGRAM, {2'h1, 16'h1234, 8'h5A}};
    rows[2] = '{isc_pkg::INS_PROGRAM, isc_pkg::OP_PROGRAM, {2'h2, 16'h0005, 8'h3C}};
    rows[3] = '{isc_pkg::INS_PROGRAM, isc_pkg::OP_PROGRAM, {2'h3, 16'h0001, 8'h81}};
    rows[4] = '{isc_pkg::INS_ERASE, isc_pkg::OP_ERASE, {2'h0, 16'h0002, 8'h00}};
    rows[5] = '{isc_pkg::INS_ERASE, isc_pkg::OP_ERASE, {2'h1, 16'h0003, 8'h00}};
    do_reset(10);
    chk(32'(tdo_oe_n), 32'h1);
    chk(32'({st_oe_n, er_oe_n}), 32'h3);
    chk(32'(pin_sel), 32'h1);
    chk(32'(active), 32'h0);
    $display("test reset done");
    enable(2'h2);
    chk(32'(tdo_oe_n), 32'h0);
    chk(32'({st_oe_n, er_oe_n}), 32'h0);
    chk(32'({st, er}), 32'h3);
    ir(8'hA7);
    dr(4, 26'hB);
    chk(32'(dout[3:0]), 32'h6);
    $display("test enable done");
    for (int r = 0; r < 6; r++) begin
      ir(rows[r].ins);
      dr(26, rows[r].dr);
      take({rows[r].op, rows[r].dr});
    end
    $display("test rows done");
    ir(isc_pkg::INS_PROGRAM);
    for (int k = 0; k < 10; k++) dr(26, {2'h0, 16'(k), 8'(k)});
    chk(32'(st), 32'h0);
    for (int k = 0; k < 9; k++) take({isc_pkg::OP_PROGRAM, 2'h0, 16'(k), 8'(k)});
    waitc(6);
    chk(32'(valid), 32'h0);
    chk(32'(st), 32'h1);
    busy = 1'b1;
    waitc(4);
    chk(32'(st), 32'h0);
    busy = 1'b0;
    waitc(6);
    chk(32'(st), 32'h1);
    $display("test queue done");
    fail = 1'b1;
    waitc(1);
    fail = 1'b0;
    waitc(12);
    chk(32'(er), 32'h0);
    ir(isc_pkg::INS_STATUS);
    dr(8, 26'h0);
    chk(32'(dout[4:0]), 32'h13);
    chk(32'(er), 32'h0);
    ir(isc_pkg::INS_CLEAR);
    waitc(4);
    chk(32'(er), 32'h1);
    fail = 1'b1;
    waitc(1);
    fail = 1'b0;
    ir(isc_pkg::INS_DISABLE);
    chk(32'({tdo_oe_n, st_oe_n, er_oe_n}), 32'h7);
    enable(2'h2);
    chk(32'(er), 32'h0);
    ir(isc_pkg::INS_DISABLE);
    crst = 1'b0;
    waitc(8);
    crst = 1'b1;
    enable(2'h2);
    chk(32'(er), 32'h1);
    $display("test error done");
    ir(isc_pkg::INS_ERASE);
    dr(26, {2'h0, 16'h0003, 8'h00});
    waitc(40);
    chk(32'(valid), 32'h0);
    ir(isc_pkg::INS_READ);
    dr(26, {2'h3, 16'h0040, 8'h00});
    chk(32'({rtgt, raddr}), 32'h00030040);
    dr(26, {2'h3, 16'h0040, 8'h00});
    chk(32'(dout[7:0]), 32'(isc_pkg::BLANK_BYTE));
    blank = 1'b0;
    waitc(3);
    chk(32'(pin_sel), 32'h0);
    dr(26, {2'h3, 16'h0040, 8'h00});
    chk(32'(dout[7:0]), 32'h5A);
    blank = 1'b1;
    $display("test protect and read done");
    sec = 1'b1;
    do_reset(3);
    chk(32'(secured), 32'h1);
    enable(2'h3);
    chk(32'({st, st_oe_n, er_oe_n}), 32'h3);
    ir(isc_pkg::INS_READ);
    dr(26, {2'h0, 16'h0040, 8'h00});
    dr(26, {2'h0, 16'h0040, 8'h00});
    chk(32'(dout[7:0]), 32'h0);
    ir(isc_pkg::INS_PROGRAM);
    dr(26, {2'h0, 16'h0020, 8'h11});
    waitc(40);
    chk(32'(valid), 32'h0);
    ir(isc_pkg::INS_CHIP_ERASE);
    dr(26, 26'h0);
    take({isc_pkg::OP_CHIP_ERASE, 26'h0});
    chk(32'(secured), 32'h0);
    $display("test secured done");
    stop_test();
  end
endmodule : test_isc_port
